// ---- verilog/irf_pkg.sv ----
// What this block does
// - Upper mask gates channels 32 to 63
// - Upper bit k governs channel 32+k
// - Upper bit 0 enables channel 32
// - Upper set 70h, clear 74h
// - Reading either upper port returns mask
// - Lower mask: set 78h, clear 7Ch
// - Lower mask gates channels 0 to 31
// - Lower bit n enables channel n
// - Source asserting edge sets event bit, except sources 28, 30 and 31
// - Writing one at set port sets event, except reserved bits 31 and 28
// - Only clear-port one clears an event
// - Event read returns events AND mask
// - Event set 80h, clear 84h
// - Event bit 30 is the extra event
// - Either enabled GP input raises bit 30
package irf_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_UPPER_SET = 8'h70;
   localparam logic [7:0] OFS_UPPER_CLR = 8'h74;
   localparam logic [7:0] OFS_LOWER_SET = 8'h78;
   localparam logic [7:0] OFS_LOWER_CLR = 8'h7C;
   localparam logic [7:0] OFS_EVENT_SET = 8'h80;
   localparam logic [7:0] OFS_EVENT_CLR = 8'h84;
   localparam int ADDR_LSB = 0;
   localparam int ADDR_MSB = 7;

   // Field layout
   localparam int GP_EVENT_BIT = 30;
   localparam int CH_UPPER_BIT = 5;
   localparam logic [31:0] EVENT_IMPL = 32'h6FFF_FFFF;
   localparam logic [31:0] MASK_RESET = 32'h0000_0000;
   localparam logic [31:0] EVENT_RESET = 32'h0000_0000;
   localparam logic [31:0] RDATA_NONE = 32'h0000_0000;

   // AHB encodings
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic HRESP_OKAY = 1'h0;

   // Bus slave states, one-hot
   typedef enum logic [2:0] {
      BUS_IDLE = 3'b001,
      BUS_WAIT = 3'b010,
      BUS_DONE = 3'b100
   } irf_bus_state_t;

   // Received isochronous packet header as seen by the filter
   typedef struct packed {
      logic valid;
      logic [5:0] channel;
   } irf_rx_pkt_t;

   // Latched address phase
   typedef struct packed {
      logic write;
      logic [7:0] addr;
   } irf_addr_phase_t;
endpackage

// ---- verilog/irf_regs.sv ----
`timescale 1ns/1ps
module irf_regs #(
   parameter int NUM_SRC = 32
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire irf_pkg::irf_rx_pkt_t rx_pkt,
   output logic rx_accept,
   output logic [5:0] rx_accept_channel,
   input wire logic [NUM_SRC-1:0] irq_src,
   input wire logic [1:0] gp_irq,
   input wire logic [1:0] gp_irq_en,
   input wire logic [31:0] irq_mask,
   output logic [31:0] irq_event
);

   irf_pkg::irf_bus_state_t state;
   irf_pkg::irf_bus_state_t next_state;
   irf_pkg::irf_addr_phase_t aphase;
   logic take;
   logic wr_go;
   logic rd_go;
   logic [31:0] upper_mask;
   logic [31:0] lower_mask;
   logic [31:0] src_prev;
   logic [31:0] src_now;
   logic gp_level;
   logic gp_prev;
   logic [31:0] edge_vec;
   logic [31:0] sw_set;
   logic [31:0] sw_clr;
   logic [31:0] ev_visible;
   logic [31:0] next_rdata;

   // Write-one port decode; zero bits have no effect
   function automatic logic [31:0] w1(input logic [7:0] a, input logic [7:0] ofs, input logic [31:0] d);
      w1 = (a == ofs) ? d : 32'h0000_0000;
   endfunction

   // Channel lookup across both mask words
   function automatic logic ch_enabled(input logic [5:0] ch, input logic [31:0] up, input logic [31:0] lo);
      logic [4:0] idx;
      idx = ch[4:0];
      ch_enabled = ch[irf_pkg::CH_UPPER_BIT] ? up[idx] : lo[idx];
   endfunction

   // Address phase accepted only when this slave is not mid transfer
   assign take = hsel && (htrans == irf_pkg::HTRANS_NONSEQ) && hready && (state != irf_pkg::BUS_WAIT);
   assign wr_go = (state == irf_pkg::BUS_WAIT) && aphase.write;
   assign rd_go = (state == irf_pkg::BUS_WAIT) && !aphase.write;
   assign hresp = irf_pkg::HRESP_OKAY;
   assign hreadyout = (state != irf_pkg::BUS_WAIT);

   // One wait state so read data comes from a flop and sees any prior write
   always_comb begin
      case (state)
         irf_pkg::BUS_IDLE: next_state = take ? irf_pkg::BUS_WAIT : irf_pkg::BUS_IDLE;
         irf_pkg::BUS_WAIT: next_state = irf_pkg::BUS_DONE;
         irf_pkg::BUS_DONE: next_state = take ? irf_pkg::BUS_WAIT : irf_pkg::BUS_IDLE;
         default: next_state = irf_pkg::BUS_IDLE;
      endcase
   end

   // Bus state register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state <= irf_pkg::BUS_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Address phase capture
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         aphase <= '0;
      end else if (take) begin
         aphase.write <= hwrite;
         aphase.addr <= haddr[irf_pkg::ADDR_MSB:irf_pkg::ADDR_LSB];
      end
   end

   // Software strobes for the event word, live only in a write data phase
   assign sw_set = wr_go ? w1(aphase.addr, irf_pkg::OFS_EVENT_SET, hwdata) : 32'h0000_0000;
   assign sw_clr = wr_go ? w1(aphase.addr, irf_pkg::OFS_EVENT_CLR, hwdata) : 32'h0000_0000;

   // Upper channel mask, set and clear ports; undefined reset made zero
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         upper_mask <= irf_pkg::MASK_RESET;
      end else if (wr_go) begin
         upper_mask <= (upper_mask | w1(aphase.addr, irf_pkg::OFS_UPPER_SET, hwdata))
                       & ~w1(aphase.addr, irf_pkg::OFS_UPPER_CLR, hwdata);
      end
   end

   // Lower channel mask, set and clear ports
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lower_mask <= irf_pkg::MASK_RESET;
      end else if (wr_go) begin
         lower_mask <= (lower_mask | w1(aphase.addr, irf_pkg::OFS_LOWER_SET, hwdata))
                       & ~w1(aphase.addr, irf_pkg::OFS_LOWER_CLR, hwdata);
      end
   end

   // Widen the source vector; absent sources read as idle
   always_comb begin
      src_now = 32'h0000_0000;
      src_now[NUM_SRC-1:0] = irq_src;
   end

   // Either enabled general-purpose input forms the extra event level
   assign gp_level = (gp_irq[0] && gp_irq_en[0]) || (gp_irq[1] && gp_irq_en[1]);

   // Asserting edges only; a held level does not refire after a clear
   always_comb begin
      edge_vec = src_now & ~src_prev & irf_pkg::EVENT_IMPL;
      edge_vec[irf_pkg::GP_EVENT_BIT] = gp_level && !gp_prev;
   end

   // Edge detector history
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         src_prev <= 32'h0000_0000;
         gp_prev <= 1'b0;
      end else begin
         src_prev <= src_now;
         gp_prev <= gp_level;
      end
   end

   // Event bits; a set in the same cycle as a clear wins
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_event <= irf_pkg::EVENT_RESET;
      end else begin
         irq_event <= ((irq_event & ~sw_clr) | edge_vec | sw_set) & irf_pkg::EVENT_IMPL;
      end
   end

   // Masked view of the event word
   assign ev_visible = irq_event & irq_mask;

   // Read mux; both ports of a pair read the same value
   always_comb begin
      case (aphase.addr)
         irf_pkg::OFS_UPPER_SET, irf_pkg::OFS_UPPER_CLR: next_rdata = upper_mask;
         irf_pkg::OFS_LOWER_SET, irf_pkg::OFS_LOWER_CLR: next_rdata = lower_mask;
         irf_pkg::OFS_EVENT_SET, irf_pkg::OFS_EVENT_CLR: next_rdata = ev_visible;
         default: next_rdata = irf_pkg::RDATA_NONE;
      endcase
   end

   // Read data loaded in the wait cycle, held until the next read
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= irf_pkg::RDATA_NONE;
      end else if (rd_go) begin
         hrdata <= next_rdata;
      end
   end

   // Receive filter; the decision is registered one cycle after the header
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_accept <= 1'b0;
         rx_accept_channel <= 6'h00;
      end else begin
         rx_accept <= rx_pkt.valid && ch_enabled(rx_pkt.channel, upper_mask, lower_mask);
         rx_accept_channel <= rx_pkt.channel;
      end
   end

   // Receive filter checks; each header is judged against the mask of its own cycle
   upper_block_a: assert property (@(posedge hclk) disable iff (!hresetn)
      rx_pkt.valid && rx_pkt.channel[irf_pkg::CH_UPPER_BIT] && !upper_mask[rx_pkt.channel[4:0]] |=> !rx_accept)
      else $error("upper channel accepted while masked");

   top_channel_a: assert property (@(posedge hclk) disable iff (!hresetn)
      rx_pkt.valid && (rx_pkt.channel == 6'h3F) |=> (rx_accept == $past(upper_mask[31])) && (rx_accept_channel == 6'h3F))
      else $error("channel 63 not governed by upper bit 31");

   base_channel_a: assert property (@(posedge hclk) disable iff (!hresetn)
      rx_pkt.valid && (rx_pkt.channel == 6'h20) |=> rx_accept == $past(upper_mask[0]))
      else $error("channel 32 not governed by upper bit 0");

   // Register port checks; write data is only valid in the wait cycle
   upper_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_go && (aphase.addr == irf_pkg::OFS_UPPER_SET) |=> upper_mask == ($past(upper_mask) | $past(hwdata)))
      else $error("upper set port did not set");

   upper_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_go && (aphase.addr == irf_pkg::OFS_UPPER_CLR) |=> upper_mask == ($past(upper_mask) & ~$past(hwdata)))
      else $error("upper clear port did not clear");

   upper_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
      rd_go && ((aphase.addr == irf_pkg::OFS_UPPER_SET) || (aphase.addr == irf_pkg::OFS_UPPER_CLR))
      |=> hreadyout && (hrdata == upper_mask))
      else $error("upper mask read mismatch");

   lower_ports_a: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_go && (aphase.addr == irf_pkg::OFS_LOWER_CLR) |=> lower_mask == ($past(lower_mask) & ~$past(hwdata)))
      else $error("lower clear port did not clear");

   lower_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_go && (aphase.addr == irf_pkg::OFS_LOWER_SET) |=> lower_mask == ($past(lower_mask) | $past(hwdata)))
      else $error("lower set port did not set");

   lower_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
      rd_go && ((aphase.addr == irf_pkg::OFS_LOWER_SET) || (aphase.addr == irf_pkg::OFS_LOWER_CLR))
      |=> hrdata == $past(lower_mask))
      else $error("lower mask read mismatch");

   idle_reject_a: assert property (@(posedge hclk) disable iff (!hresetn)
      !rx_pkt.valid |=> !rx_accept)
      else $error("accept without a received header");

   channel_echo_a: assert property (@(posedge hclk) disable iff (!hresetn)
      rx_pkt.valid |=> rx_accept_channel == $past(rx_pkt.channel))
      else $error("accepted channel number mismatch");

   lower_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
      rx_pkt.valid && !rx_pkt.channel[5] |=> rx_accept == $past(lower_mask[rx_pkt.channel[4:0]]))
      else $error("lower channel gate mismatch");

   lower_map_a: assert property (@(posedge hclk) disable iff (!hresetn)
      rx_pkt.valid && (rx_pkt.channel == 6'h1E) |=> rx_accept == $past(lower_mask[30]))
      else $error("channel 30 not governed by lower bit 30");

   edge_sets_a: assert property (@(posedge hclk) disable iff (!hresetn)
      edge_vec != 32'h0000_0000 |=> (irq_event & $past(edge_vec)) == $past(edge_vec))
      else $error("asserting edge lost");

   soft_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
      sw_set != 32'h0000_0000
      |=> (irq_event & $past(sw_set) & irf_pkg::EVENT_IMPL) == ($past(sw_set) & irf_pkg::EVENT_IMPL))
      else $error("set port did not set event");

   only_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
      1'b1 |=> ($past(irq_event) & ~irq_event & ~$past(sw_clr)) == 32'h0000_0000)
      else $error("event dropped without clear write");

   // Masked reads are built from the raw inputs, not from the read mux
   masked_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
      rd_go && (aphase.addr == irf_pkg::OFS_EVENT_CLR) |=> hrdata == ($past(irq_event) & $past(irq_mask)))
      else $error("event read not masked");

   event_set_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
      rd_go && (aphase.addr == irf_pkg::OFS_EVENT_SET) |=> hrdata == ($past(irq_event) & $past(irq_mask)))
      else $error("event set port read not masked");

   event_ports_a: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_go && (aphase.addr == irf_pkg::OFS_EVENT_CLR) && (edge_vec == 32'h0000_0000)
      |=> irq_event == ($past(irq_event) & ~$past(hwdata)))
      else $error("event clear port mismatch");

   gp_event_a: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(gp_level) |=> irq_event[irf_pkg::GP_EVENT_BIT]
      ##1 (irq_event[irf_pkg::GP_EVENT_BIT] || $past(sw_clr[irf_pkg::GP_EVENT_BIT])))
      else $error("general-purpose edge missed its event bit");

   reserved_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (irq_event & ~irf_pkg::EVENT_IMPL) == 32'h0000_0000)
      else $error("reserved event bit set");

   // Watched at the pins so a broken enable gate is caught
   gp_rise_a: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(|(gp_irq & gp_irq_en)) |=> irq_event[irf_pkg::GP_EVENT_BIT])
      else $error("enabled general-purpose input missed");

   gp_quiet_a: assert property (@(posedge hclk) disable iff (!hresetn)
      ((gp_irq & gp_irq_en) == 2'h0) && !irq_event[irf_pkg::GP_EVENT_BIT] && !sw_set[irf_pkg::GP_EVENT_BIT]
      |=> !irq_event[irf_pkg::GP_EVENT_BIT])
      else $error("disabled general-purpose input raised event");

   zero_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_go && (hwdata == 32'h0000_0000) |=> (upper_mask == $past(upper_mask)) && (lower_mask == $past(lower_mask)))
      else $error("zero write changed a mask");

   bus_wait_a: assert property (@(posedge hclk) disable iff (!hresetn)
      take |=> !hreadyout ##1 hreadyout)
      else $error("transfer not one wait state");

endmodule

// ---- verif/iso_rx_channel_filter_and_irq_event_tb_top.sv ----
`timescale 1ns/1ps
module iso_rx_channel_filter_and_irq_event_tb_top;
   typedef struct packed {
      logic wr;
      logic [7:0] addr;
      logic [31:0] data;
   } irf_row_t;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, rx_accept;
   logic [31:0] haddr, hwdata, hrdata, irq_src, irq_mask, irq_event, rd;
   logic [1:0] htrans, gp_irq, gp_irq_en;
   logic [2:0] hsize;
   logic [5:0] rx_accept_channel;
   irf_pkg::irf_rx_pkt_t rx_pkt;
   int n_mismatch, checks, ch;
   logic [31:0] up_m = 32'h0FFF_0001;
   logic [31:0] lo_m = 32'h8000_0020;
   // Each write row followed by a read row; a read row carries the expected word
   irf_row_t rows [16] = '{'{1'h1, 8'h70, 32'hFFFF_0001}, '{1'h0, 8'h70, 32'hFFFF_0001},
      '{1'h1, 8'h74, 32'hF000_0000}, '{1'h0, 8'h74, 32'h0FFF_0001}, '{1'h1, 8'h78, 32'h8000_0021},
      '{1'h0, 8'h7C, 32'h8000_0021}, '{1'h1, 8'h7C, 32'h0000_0001}, '{1'h0, 8'h78, 32'h8000_0020},
      '{1'h1, 8'h88, 32'hFFFF_FFFF}, '{1'h0, 8'h88, 32'h0000_0000}, '{1'h1, 8'h80, 32'hFFFF_FFFF},
      '{1'h0, 8'h84, 32'h6FFF_0F0F}, '{1'h1, 8'h84, 32'h0000_000F}, '{1'h0, 8'h80, 32'h6FFF_0F00},
      '{1'h1, 8'h84, 32'hFFFF_FFFF}, '{1'h0, 8'h80, 32'h0000_0000}};

   irf_regs dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .rx_pkt(rx_pkt), .rx_accept(rx_accept),
      .rx_accept_channel(rx_accept_channel), .irq_src(irq_src), .gp_irq(gp_irq), .gp_irq_en(gp_irq_en),
      .irq_mask(irq_mask), .irq_event(irq_event));

   // 200 MHz clock
   initial begin
      hclk = 1'h0;
      forever #2.5 hclk = ~hclk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Single word transfer; waits on hready, never on a fixed count
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      int n;
      n = 0;
      hsel <= 1'h1;
      htrans <= irf_pkg::HTRANS_NONSEQ;
      hwrite <= wr;
      haddr <= {24'h0, a};
      do begin @(posedge hclk); n++; end while (hreadyout !== 1'h1 && n < 20);
      htrans <= 2'h0;
      hsel <= 1'h0;
      hwdata <= d;
      do begin @(posedge hclk); n++; end while (hreadyout !== 1'h1 && n < 40);
      if (n >= 40) n_mismatch++;
      r = hrdata;
      chk({31'h0, hresp}, {31'h0, irf_pkg::HRESP_OKAY});
   endtask

   // Reset for 5 cycles; sources quiet so no edge is seen at release
   task automatic do_reset();
      hresetn <= 1'h0;
      repeat (5) @(posedge hclk);
      chk(irq_event, irf_pkg::EVENT_RESET);
      chk({31'h0, hreadyout}, 32'h1);
      hresetn <= 1'h1;
      @(posedge hclk);
   endtask

   task automatic finish_test();
      $display("comparisons=%0d mismatches=%0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // Watchdog well beyond the expected run
   initial begin
      #100000;
      n_mismatch++;
      finish_test();
   end

   initial begin
      {hresetn, hsel, hwrite, haddr, hwdata, htrans, hsize} = '0;
      {rx_pkt, irq_src, gp_irq, gp_irq_en} = '0;
      irq_mask = 32'hFFFF_0F0F;
      n_mismatch = 0;
      checks = 0;
      @(posedge hclk);
      hsize <= 3'h2;
      do_reset();
      ahb(1'h0, 8'h70, 32'h0, rd);
      chk(rd, irf_pkg::MASK_RESET);
      // Masks written before any header relies on them
      foreach (rows[i]) begin
         ahb(rows[i].wr, rows[i].addr, rows[i].data, rd);
         if (!rows[i].wr) chk(rd, rows[i].data);
      end
      // Every channel back to back, then three invalid headers, only the first checked
      for (int i = 0; i < 67; i++) begin
         @(posedge hclk);
         ch = i - 2;
         if (i >= 2) chk({31'h0, rx_accept}, {31'h0, (ch > 63) ? 1'h0 : (ch >= 32) ? up_m[ch-32] : lo_m[ch]});
         if (i >= 2 && ch < 64) chk({26'h0, rx_accept_channel}, 32'(ch));
         rx_pkt <= '{valid: (i < 64), channel: i[5:0]};
      end
      // Reserved sources and a disabled input must not latch
      irq_mask <= 32'hFFFF_FFFF;
      irq_src <= 32'hD000_0008;
      gp_irq_en <= 2'h1;
      gp_irq <= 2'h2;
      repeat (3) @(posedge hclk);
      chk(irq_event, 32'h0000_0008);
      gp_irq <= 2'h3;
      repeat (3) @(posedge hclk);
      chk(irq_event, 32'h4000_0008);
      // Source still high after clear: no new edge, bit stays clear
      ahb(1'h1, 8'h84, 32'h0000_0008, rd);
      repeat (3) @(posedge hclk);
      chk(irq_event, 32'h4000_0000);
      irq_mask <= 32'hC000_00FF;
      ahb(1'h0, 8'h84, 32'h0, rd);
      chk(rd, 32'h4000_0000);
      // Second input alone, with only its own enable
      gp_irq <= 2'h0;
      gp_irq_en <= 2'h2;
      ahb(1'h1, 8'h84, 32'h4000_0000, rd);
      chk(irq_event, 32'h0000_0000);
      gp_irq <= 2'h2;
      repeat (3) @(posedge hclk);
      chk(irq_event, 32'h4000_0000);
      irq_src <= 32'h0;
      gp_irq <= 2'h0;
      @(posedge hclk);
      do_reset();
      ahb(1'h0, 8'h7C, 32'h0, rd);
      chk(rd, irf_pkg::MASK_RESET);
      finish_test();
   end
endmodule
